/* verilog/srd_pkg.sv */
/*
  Shared constants and carrier types for the I/O and register-move decoder.
  Assumes a 32-bit instruction pair delivered by the script fetch path.
*/
package srd_pkg;

  localparam int OPC_HI       = 29;
  localparam int OPC_LO       = 27;
  localparam int TYPE_HI      = 31;
  localparam int TYPE_LO      = 30;
  localparam int OPR_HI       = 26;
  localparam int OPR_LO       = 24;
  localparam int REL_BIT      = 26;
  localparam int TBL_BIT      = 25;
  localparam int SELATN_BIT   = 24;
  localparam int ID_HI        = 18;
  localparam int ID_LO        = 16;
  localparam int RA_HI        = 22;
  localparam int RA_LO        = 16;
  localparam int CARRY_BIT    = 10;
  localparam int TGT_BIT      = 9;
  localparam int ACK_BIT      = 6;
  localparam int ATN_BIT      = 3;
  localparam int OFS_HI       = 23;
  localparam int IMM_HI       = 15;
  localparam int IMM_LO       = 8;
  localparam int TGT_FIELD    = 0;
  localparam int NUM_REGS     = 128;

  localparam logic [1:0] TYPE_IO_RW  = 2'h1;
  localparam logic [2:0] OPC_SELECT  = 3'h0;
  localparam logic [2:0] OPC_WDISC   = 3'h1;
  localparam logic [2:0] OPC_WRESEL  = 3'h2;
  localparam logic [2:0] OPC_SET     = 3'h3;
  localparam logic [2:0] OPC_CLEAR   = 3'h4;
  localparam logic [2:0] OPC_MOVFROM = 3'h5;
  localparam logic [2:0] OPC_MOVTO   = 3'h6;
  localparam logic [2:0] OPC_RMW     = 3'h7;

  localparam logic [2:0] OPR_MOVE = 3'h0;
  localparam logic [2:0] OPR_SHL  = 3'h1;
  localparam logic [2:0] OPR_OR   = 3'h2;
  localparam logic [2:0] OPR_XOR  = 3'h3;
  localparam logic [2:0] OPR_AND  = 3'h4;
  localparam logic [2:0] OPR_SHR  = 3'h5;
  localparam logic [2:0] OPR_ADD  = 3'h6;
  localparam logic [2:0] OPR_ADC  = 3'h7;

  localparam logic [6:0] FBR_ADDR   = 7'h08;
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [31:0] ADDR_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    AM_DIRECT,
    AM_TABLE_INDIRECT,
    AM_RELATIVE,
    AM_TABLE_RELATIVE
  } srd_amode_t;

  typedef struct packed {
    logic [31:0] first;
    logic [31:0] second;
    logic [31:0] dsp;
  } srd_instr_t;

  typedef struct packed {
    logic        fetch_table;
    logic [31:0] table_addr;
    logic [31:0] alt_addr;
    logic [2:0]  dest_id;
    logic        use_instr_id;
  } srd_io_t;

endpackage : srd_pkg

/* verilog/srd_alu.sv */
/*
  Byte ALU for register moves.
  Assumes operands are already selected; purely combinational.
*/
`timescale 1ns/1ns
module srd_alu
  import srd_pkg::*;
(
  input  wire logic [2:0] op,
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       carry_in,
  output logic      [7:0] result,
  output logic            carry_out
);

  wire logic [8:0] sum_w  = {1'b0, a} + {1'b0, b};
  wire logic [8:0] sumc_w = sum_w + {8'h00, carry_in};

  // Shifts act on the register operand; b unused there
  always_comb begin
    result    = a;
    carry_out = carry_in;
    unique case (op)
      OPR_MOVE: result = b;
      OPR_SHL: begin
        result    = {a[6:0], carry_in};
        carry_out = a[7];
      end
      OPR_OR:  result = a | b;
      OPR_XOR: result = a ^ b;
      OPR_AND: result = a & b;
      OPR_SHR: begin
        result    = {carry_in, a[7:1]};
        carry_out = a[0];
      end
      OPR_ADD: begin
        result    = sum_w[7:0];
        carry_out = sum_w[8];
      end
      OPR_ADC: begin
        result    = sumc_w[7:0];
        carry_out = sumc_w[8];
      end
    endcase
  end

endmodule : srd_alu

/* verilog/srd_io_addr.sv */
/*
  Address generation for I/O instructions by addressing mode.
  Assumes dsp is the address of the current instruction's next word.
*/
`timescale 1ns/1ns
module srd_io_addr
  import srd_pkg::*;
(
  input  wire srd_instr_t  instr,
  input  wire logic [31:0] data_structure_base_reg,
  output srd_io_t          io
);

  wire logic        rel_w  = instr.first[REL_BIT];
  wire logic        tbl_w  = instr.first[TBL_BIT];
  wire logic [31:0] ofs1_w = {{8{instr.first[OFS_HI]}}, instr.first[OFS_HI:0]};
  wire logic [31:0] ofs2_w = {{8{instr.second[OFS_HI]}}, instr.second[OFS_HI:0]};

  // Direct/indirect use the word itself; relative forms add to the pointer
  assign io.alt_addr     = rel_w ? instr.dsp + ofs2_w : instr.second;
  assign io.fetch_table  = tbl_w;
  assign io.table_addr   = data_structure_base_reg + ofs1_w;
  assign io.use_instr_id = !tbl_w;
  assign io.dest_id      = instr.first[ID_HI:ID_LO];

endmodule : srd_io_addr

/* verilog/srd_decoder.sv */
/*
  Decoder and executor for I/O field and register read/write instructions.
  Assumes one instruction pair per start pulse from the fetch path; table data
  is fetched elsewhere using table_addr when fetch_table is high.
*/
`timescale 1ns/1ns
module srd_decoder
  import srd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire srd_instr_t  instr,
  input  wire logic [31:0] data_structure_base_reg,
  input  wire logic        loopback_en,
  input  wire logic        sel_phase,
  input  wire logic        sel_failed,
  input  wire logic        table_valid,
  input  wire logic [31:0] table_data,
  output logic             is_io,
  output logic             is_rw,
  output srd_amode_t       amode,
  output srd_io_t          io_info,
  output logic [31:0]      next_address_reg,
  output logic [31:0]      dest_addr,
  output logic             take_alt,
  output logic             illegal_instr,
  output logic             carry,
  output logic [7:0]       bus_control_zero_reg,
  output logic [7:0]       bus_control_three_reg,
  output logic [7:0]       output_control_latch_reg,
  output logic [7:0]       first_byte_received_reg,
  output logic [2:0]       table_dest_id,
  output logic [7:0]       sync_xfer,
  output logic             attention_out_sig,
  output logic             acknowledge_out_sig,
  output logic             done
);

  ////////////////////////////////////////////////////////////////////////////
  // Field decode

  wire logic [2:0] opc_w    = instr.first[OPC_HI:OPC_LO];
  wire logic [2:0] opr_w    = instr.first[OPR_HI:OPR_LO];
  wire logic [6:0] raddr_w  = instr.first[RA_HI:RA_LO];
  wire logic [7:0] imm_w    = instr.first[IMM_HI:IMM_LO];
  wire logic       type_ok_w = instr.first[TYPE_HI:TYPE_LO] == TYPE_IO_RW;
  wire logic       io_w     = type_ok_w && (opc_w <= OPC_CLEAR);
  wire logic       rw_w     = type_ok_w && (opc_w > OPC_CLEAR);
  wire logic       set_w    = io_w && opc_w == OPC_SET;
  wire logic       clr_w    = io_w && opc_w == OPC_CLEAR;
  wire logic       sel_w    = io_w && opc_w == OPC_SELECT;
  wire logic       selatn_w = instr.first[SELATN_BIT];
  wire logic       bad_w    = io_w && !sel_w && selatn_w;

  assign is_io = io_w;
  assign is_rw = rw_w;
  assign amode = srd_amode_t'({instr.first[REL_BIT], instr.first[TBL_BIT]});

  srd_io_addr u_addr (
    .instr (instr),
    .data_structure_base_reg   (data_structure_base_reg),
    .io    (io_info)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Internal register file and ALU

  logic [7:0] regs_reg [NUM_REGS];
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] alu_y;
  logic       alu_c;

  wire logic [7:0] sel_reg_w = (raddr_w == FBR_ADDR) ? first_byte_received_reg
                                                     : regs_reg[raddr_w];
  wire logic       to_fbr_w   = opc_w == OPC_MOVTO;
  wire logic       from_fbr_w = opc_w == OPC_MOVFROM;

  // Move-from operates on the first-byte register, others on the addressed one
  assign alu_a = from_fbr_w ? first_byte_received_reg : sel_reg_w;
  assign alu_b = imm_w;

  srd_alu u_alu (
    .op        (opr_w),
    .a         (alu_a),
    .b         (alu_b),
    .carry_in  (carry),
    .result    (alu_y),
    .carry_out (alu_c)
  );

  wire logic wr_fbr_w = rw_w && (to_fbr_w || raddr_w == FBR_ADDR);
  wire logic wr_reg_w = rw_w && !to_fbr_w && raddr_w != FBR_ADDR;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: execute, then optionally wait for table data

  typedef enum logic [1:0] {ST_IDLE, ST_TABLE, ST_DONE} srd_state_t;
  srd_state_t state_reg;
  srd_state_t state_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (start) begin
        state_next = (io_w && io_info.fetch_table && !bad_w) ? ST_TABLE : ST_DONE;
      end
      ST_TABLE: if (table_valid) begin
        state_next = ST_DONE;
      end
      ST_DONE:  state_next = ST_IDLE;
    endcase
  end

  wire logic exec_w = (state_reg == ST_IDLE) && start;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign done = state_reg == ST_DONE;

  ////////////////////////////////////////////////////////////////////////////
  // Register file writes

  generate
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          regs_reg[i] <= REG_RESET;
        end else if (exec_w && wr_reg_w && raddr_w == 7'(i)) begin
          regs_reg[i] <= alu_y;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      first_byte_received_reg <= REG_RESET;
    end else if (exec_w && wr_fbr_w) begin
      first_byte_received_reg <= alu_y;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Set / Clear effects and carry

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      carry <= 1'b0;
    end else if (exec_w && rw_w) begin
      carry <= alu_c;
    end else if (exec_w && (set_w || clr_w) && instr.first[CARRY_BIT]) begin
      carry <= set_w;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_control_zero_reg <= REG_RESET;
    end else if (exec_w && (set_w || clr_w) && instr.first[TGT_BIT]) begin
      bus_control_zero_reg[TGT_FIELD] <= set_w;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      output_control_latch_reg <= REG_RESET;
    end else if (exec_w && (set_w || clr_w)) begin
      if (instr.first[ACK_BIT]) begin
        output_control_latch_reg[ACK_BIT] <= set_w;
      end
      if (instr.first[ATN_BIT]) begin
        output_control_latch_reg[ATN_BIT] <= set_w;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction state: selection attention, addresses, illegal flag

  logic sel_atn_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sel_atn_reg      <= 1'b0;
      illegal_instr    <= 1'b0;
      next_address_reg <= ADDR_ZERO;
      dest_addr        <= ADDR_ZERO;
    end else if (exec_w) begin
      sel_atn_reg      <= sel_w && selatn_w;
      illegal_instr    <= bad_w;
      next_address_reg <= io_w ? io_info.alt_addr : next_address_reg;
      dest_addr        <= rw_w ? instr.second : dest_addr;
    end
  end

  // Alternate path is taken only when the link reports a failed selection
  assign take_alt = sel_failed;

  ////////////////////////////////////////////////////////////////////////////
  // Table fetch load: control three, ID, offset/period

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_control_three_reg <= REG_RESET;
      table_dest_id         <= 3'h0;
      sync_xfer             <= REG_RESET;
    end else if (state_reg == ST_TABLE && table_valid) begin
      bus_control_three_reg <= table_data[31:24];
      table_dest_id         <= table_data[18:16];
      sync_xfer             <= table_data[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus drive of initiator signals

  wire logic drive_ok_w = !bus_control_zero_reg[TGT_FIELD] || loopback_en;

  assign attention_out_sig   = drive_ok_w && (output_control_latch_reg[ATN_BIT]
                               || (sel_phase && sel_atn_reg));
  assign acknowledge_out_sig = drive_ok_w && output_control_latch_reg[ACK_BIT];

endmodule : srd_decoder

/* sim/srd_table_mem.sv */
/*
  Script memory model answering table fetches of the decoder.
  Assumes fetch_table and table_addr stay put until the word is delivered.
*/
`timescale 1ns/1ns
module srd_table_mem
  import srd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        fetch_table,
  input  wire logic [31:0] table_addr,
  input  wire logic [3:0]  lat,
  output logic             table_valid,
  output logic [31:0]      table_data
);
  logic [3:0] cnt_reg;
  logic       served_reg;
  ////////////////////////////////////////
  // Word is the inverted address; between words the bus toggles, never holds
  always_ff @(posedge ref_clk) begin
    table_valid <= 1'h0;
    table_data  <= ~table_data;
    if (rst) begin
      cnt_reg     <= 4'h0;
      served_reg  <= 1'h0;
      table_data  <= 32'h0000_0000;
    end else if (!fetch_table) begin
      served_reg <= 1'h0;
    end else if (!served_reg && cnt_reg == lat) begin
      table_valid <= 1'h1;
      table_data  <= ~table_addr;
      served_reg  <= 1'h1;
      cnt_reg     <= 4'h0;
    end else if (!served_reg) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : srd_table_mem

/* sim/srd_decoder_monitor.sv */
/*
  Port-level checker for the decoder.
  Assumes it is bound onto srd_decoder and sees only its ports.
*/
`timescale 1ns/1ns
module srd_decoder_monitor
  import srd_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        start,
  input wire srd_instr_t  instr,
  input wire logic [31:0] data_structure_base_reg,
  input wire logic        loopback_en,
  input wire logic        table_valid,
  input wire logic [31:0] table_data,
  input wire logic        is_io,
  input wire logic        is_rw,
  input wire srd_io_t     io_info,
  input wire logic [31:0] dest_addr,
  input wire logic        illegal_instr,
  input wire logic        carry,
  input wire logic [7:0]  bus_control_zero_reg,
  input wire logic [7:0]  output_control_latch_reg,
  input wire logic [2:0]  table_dest_id,
  input wire logic [7:0]  sync_xfer,
  input wire logic        attention_out_sig,
  input wire logic        acknowledge_out_sig,
  input wire logic        done
);
  logic busy_reg;
  wire  take   = start && !busy_reg;
  wire  io_go  = take && is_io && !instr.first[25] && !instr.first[24];
  wire  set_go = io_go && instr.first[29:27] == OPC_SET;
  wire  clr_go = io_go && instr.first[29:27] == OPC_CLEAR;
  ////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (rst || done) busy_reg <= 1'h0;
    else if (take) busy_reg <= 1'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_type; is_io == (instr.first[31:30] == TYPE_IO_RW &&
    instr.first[29:27] <= OPC_CLEAR); endproperty
  a_type: assert property (p_type) else $error("io decode wrong");
  property p_id; is_io && !instr.first[25] |-> io_info.dest_id == instr.first[18:16];
  endproperty
  a_id: assert property (p_id) else $error("dest id wrong");
  property p_tbl; io_info.fetch_table |-> io_info.table_addr == data_structure_base_reg +
    {{8{instr.first[23]}}, instr.first[23:0]}; endproperty
  a_tbl: assert property (p_tbl) else $error("table address wrong");
  property p_rel; is_io && instr.first[26] |-> io_info.alt_addr == instr.dsp +
    {{8{instr.second[23]}}, instr.second[23:0]}; endproperty
  a_rel: assert property (p_rel) else $error("relative address wrong");
  property p_carry; set_go && instr.first[10] |=> done && carry; endproperty
  a_carry: assert property (p_carry) else $error("carry not set");
  property p_tgt; clr_go && instr.first[9] |=> !bus_control_zero_reg[0]; endproperty
  a_tgt: assert property (p_tgt) else $error("target bit not cleared");
  property p_latch; set_go |=> output_control_latch_reg[6] ==
    ($past(instr.first[6]) | $past(output_control_latch_reg[6])); endproperty
  a_latch: assert property (p_latch) else $error("latch bit wrong");
  property p_drive; attention_out_sig || acknowledge_out_sig |->
    !bus_control_zero_reg[TGT_FIELD] || loopback_en; endproperty
  a_drive: assert property (p_drive) else $error("driven as target");
  property p_rwd; take && is_rw |=> dest_addr == $past(instr.second); endproperty
  a_rwd: assert property (p_rwd) else $error("dest address wrong");
  // Busy without done is the table wait; stray words at other times are ignored
  property p_tload; busy_reg && !done && table_valid |=> done && sync_xfer ==
    $past(table_data[15:8]) && table_dest_id == $past(table_data[18:16]); endproperty
  a_tload: assert property (p_tload) else $error("table load wrong");
  property p_ill; take && is_io && instr.first[24] &&
    instr.first[29:27] != OPC_SELECT |=> done && illegal_instr; endproperty
  a_ill: assert property (p_ill) else $error("illegal not flagged");
  c_tbl: cover property (busy_reg && !done && table_valid);
  c_ill: cover property (illegal_instr);
  c_rw: cover property (take && is_rw);
endmodule : srd_decoder_monitor
bind srd_decoder srd_decoder_monitor u_mon (.ref_clk, .rst, .start, .instr, .data_structure_base_reg,
  .loopback_en, .table_valid, .table_data, .is_io, .is_rw, .io_info, .dest_addr,
  .illegal_instr, .carry, .bus_control_zero_reg, .output_control_latch_reg,
  .table_dest_id, .sync_xfer, .attention_out_sig, .acknowledge_out_sig, .done);

/* sim/tb.sv */
/*
  Self-checking bench for the decoder with a table memory model.
  Assumes inputs change on the falling edge and one instruction at a time.
*/
`timescale 1ns/1ns
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb import srd_pkg::*; ;
  logic        ref_clk, rst, start, loopback_en, sel_phase, sel_failed, table_valid;
  logic        is_io, is_rw, take_alt, illegal_instr, carry, done;
  logic        attention_out_sig, acknowledge_out_sig;
  logic [3:0]  lat;
  logic [2:0]  table_dest_id;
  logic [7:0]  bus_control_zero_reg, bus_control_three_reg, output_control_latch_reg;
  logic [7:0]  first_byte_received_reg, sync_xfer;
  logic [31:0] data_structure_base_reg, table_data, next_address_reg, dest_addr;
  srd_instr_t  instr;
  srd_amode_t  amode;
  srd_io_t     io_info;
  int          num_errors = 0;
  int          tests_run = 0;
  ////////////////////////////////////////
  srd_decoder u_dut (.ref_clk, .rst, .start, .instr, .data_structure_base_reg, .loopback_en, .sel_phase,
    .sel_failed, .table_valid, .table_data, .is_io, .is_rw, .amode, .io_info,
    .next_address_reg, .dest_addr, .take_alt, .illegal_instr, .carry,
    .bus_control_zero_reg, .bus_control_three_reg, .output_control_latch_reg,
    .first_byte_received_reg, .table_dest_id, .sync_xfer, .attention_out_sig,
    .acknowledge_out_sig, .done);
  srd_table_mem u_mem (.ref_clk, .rst, .fetch_table(io_info.fetch_table),
    .table_addr(io_info.table_addr), .lat, .table_valid, .table_data);
  function automatic logic [31:0] io_w(logic [2:0] o, logic [1:0] m, logic a,
    logic [23:0] lo);
    return {TYPE_IO_RW, o, m, a, lo};
  endfunction : io_w
  function automatic logic [31:0] rw_w(logic [2:0] o, logic [2:0] p, logic [6:0] ra,
    logic [7:0] imm);
    return {TYPE_IO_RW, o, p, 1'h0, ra, imm, 8'h00};
  endfunction : rw_w
  task automatic test_done();
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // Instr stays up until done, so the table fetch sees a steady address
  task automatic exec(input logic [31:0] f, input logic [31:0] s);
    @(negedge ref_clk);
    instr = '{f, s, 32'h0000_2000};
    start = 1'h1;
    @(negedge ref_clk);
    start = 1'h0;
    for (int i = 0; i < 40 && done !== 1'h1; i++) @(negedge ref_clk);
    if (done !== 1'h1) begin
      num_errors++;
      test_done();
    end
  endtask : exec
  task automatic t_set_clear();
    exec(io_w(OPC_SET, 2'h0, 1'h0, 24'h00_0048), 32'h0000_0000);
    `CHK("ocl", 8'h48, output_control_latch_reg & 8'h48)
    `CHK("atn_ack", 2'h3, {attention_out_sig, acknowledge_out_sig})
    exec(io_w(OPC_SET, 2'h0, 1'h0, 24'h00_0600), 32'h0000_0000);
    `CHK("carry", 1'h1, carry)
    `CHK("tgt", 1'h1, bus_control_zero_reg[0])
    `CHK("atn_tgt", 2'h0, {attention_out_sig, acknowledge_out_sig})
    loopback_en = 1'h1;
    #1;
    `CHK("atn_loop", 2'h3, {attention_out_sig, acknowledge_out_sig})
    loopback_en = 1'h0;
    exec(io_w(OPC_CLEAR, 2'h0, 1'h0, 24'h00_0648), 32'h0000_0000);
    `CHK("clr", 4'h0, {carry, bus_control_zero_reg[0], output_control_latch_reg[6],
      output_control_latch_reg[3]})
  endtask : t_set_clear
  task automatic t_sel_atn();
    sel_phase = 1'h1;
    exec(io_w(OPC_SELECT, 2'h0, 1'h1, 24'h05_0000), 32'h0000_0100);
    `CHK("sel_atn", 1'h1, attention_out_sig)
    `CHK("legal", 1'h0, illegal_instr)
    exec(io_w(OPC_SELECT, 2'h0, 1'h0, 24'h05_0000), 32'h0000_0100);
    `CHK("sel_noatn", 1'h0, attention_out_sig)
    sel_phase = 1'h0;
    exec(io_w(OPC_WDISC, 2'h0, 1'h1, 24'h05_0000), 32'h0000_0100);
    `CHK("illegal", 1'h1, illegal_instr)
  endtask : t_sel_atn
  // Table word is the inverted table address in the memory model
  task automatic t_modes();
    logic [31:0] ta;
    ta = 32'h0003_0040;
    for (int m = 0; m < 4; m++) begin
      lat = 4'(m * 3);
      exec(io_w(OPC_SELECT, 2'(m), 1'h0, 24'hF3_0040), 32'h00FF_FFFC);
      `CHK("io", 2'h2, {is_io, is_rw})
      `CHK("amode", srd_amode_t'(m), amode)
      `CHK("alt", m[1] ? 32'h0000_1FFC : 32'h00FF_FFFC, next_address_reg)
      if (m[0]) begin
        `CHK("tbl_id", ~ta[18:16], table_dest_id)
        `CHK("ctl3", ~ta[31:24], bus_control_three_reg)
        `CHK("xfer", ~ta[15:8], sync_xfer)
      end else begin
        `CHK("id", 3'h3, io_info.dest_id)
      end
    end
    sel_failed = 1'h1;
    #1;
    `CHK("take_alt", 1'h1, take_alt)
  endtask : t_modes
  task automatic t_rw();
    logic [7:0] exp [1:6];
    // Carry is set when the loop starts, and shifts bring carry in
    exp = '{8'h2D, 8'hBE, 8'hAA, 8'h14, 8'hCB, 8'hD2};
    exec(rw_w(OPC_RMW, OPR_MOVE, FBR_ADDR, 8'h5A), 32'h1234_5678);
    `CHK("rw", 2'h1, {is_io, is_rw})
    `CHK("dest", 32'h1234_5678, dest_addr)
    `CHK("fbr_imm", 8'h5A, first_byte_received_reg)
    exec(rw_w(OPC_MOVFROM, OPR_OR, 7'h10, 8'h00), 32'h0000_0000);
    exec(rw_w(OPC_RMW, OPR_ADD, 7'h10, 8'hFF), 32'h0000_0000);
    exec(rw_w(OPC_RMW, OPR_MOVE, FBR_ADDR, 8'h00), 32'h0000_0000);
    exec(rw_w(OPC_MOVTO, OPR_OR, 7'h10, 8'h00), 32'h0000_0000);
    `CHK("copy", 8'h59, first_byte_received_reg)
    for (int k = 1; k < 7; k++) begin
      exec(rw_w(OPC_RMW, OPR_MOVE, FBR_ADDR, 8'h96), 32'h0000_0000);
      exec(rw_w(OPC_RMW, 3'(k), FBR_ADDR, 8'h3C), 32'h0000_0000);
      `CHK("alu", exp[k], first_byte_received_reg)
    end
  endtask : t_rw
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    rst = 1'h1;
    start = 1'h0;
    loopback_en = 1'h0;
    sel_phase = 1'h0;
    sel_failed = 1'h0;
    lat = 4'h0;
    data_structure_base_reg = 32'h0010_0000;
    instr = '0;
    repeat (10) @(negedge ref_clk);
    rst = 1'h0;
    t_set_clear();
    t_sel_atn();
    t_modes();
    t_rw();
    test_done();
  end
endmodule : tb
